/* core/bsf_pkg.sv */
// ==========================================================================
// bit shift flag unit package
package bsf_pkg;

	// ======================================================================
	// operation codes presented on the issue port
	typedef enum logic [4:0] {
		BSF_OP_NONE       = 5'h00,
		BSF_OP_ROT_LEFT   = 5'h01,
		BSF_OP_ROT_RIGHT  = 5'h02,
		BSF_OP_ARITH_SHR  = 5'h03,
		BSF_OP_NIB_SWAP   = 5'h04,
		BSF_OP_BIT_TO_T   = 5'h05,
		BSF_OP_T_TO_BIT   = 5'h06,
		BSF_OP_FLAG_SET   = 5'h07,
		BSF_OP_FLAG_CLEAR = 5'h08,
		BSF_OP_SLEEP      = 5'h09,
		BSF_OP_WDOG_RST   = 5'h0A,
		BSF_OP_BREAK      = 5'h0B
	} bsf_op_t;

	// ======================================================================
	// status flag bit positions
	localparam logic [2:0] BSF_FLAG_C = 3'h0;
	localparam logic [2:0] BSF_FLAG_Z = 3'h1;
	localparam logic [2:0] BSF_FLAG_N = 3'h2;
	localparam logic [2:0] BSF_FLAG_V = 3'h3;
	localparam logic [2:0] BSF_FLAG_S = 3'h4;
	localparam logic [2:0] BSF_FLAG_H = 3'h5;
	localparam logic [2:0] BSF_FLAG_T = 3'h6;
	localparam logic [2:0] BSF_FLAG_I = 3'h7;

	// ======================================================================
	// reset values
	localparam logic [7:0] BSF_FLAGS_RST  = 8'h00;
	localparam logic [7:0] BSF_RESULT_RST = 8'h00;

	// ======================================================================
	// one issued instruction
	typedef struct packed {
		bsf_op_t    op;      // operation
		logic [2:0] sel;     // bit or flag index
		logic [7:0] operand; // register value
	} bsf_req_t;

	// result written back to the register file
	typedef struct packed {
		logic       we;    // register write strobe
		logic [7:0] value; // new register value
	} bsf_wb_t;

endpackage : bsf_pkg

/* core/bsf_unit.sv */
// What this block does
// - rotate left via carry, update ZCNV
// - rotate right via carry, update ZCNV
// - arithmetic shift right keeps sign, update ZCNV
// - swap register nibbles, flags untouched
// - copy selected register bit into T
// - write T into selected register bit
// - set or clear half carry only
// - set or clear signed flag only
// - set or clear overflow flag only
// - sleep issues one cycle, flags kept
// - watchdog restart pulse, flags kept
// - break leaves flags unchanged
`timescale 1ns/1ns
`default_nettype none

module bsf_unit
	import bsf_pkg::*;
(
	// clock and reset
	input  wire logic       i_clk,
	input  wire logic       i_srst,
	// instruction issue
	input  wire logic       i_valid,
	input  wire bsf_req_t   i_req,
	// register write back
	output var  bsf_wb_t    o_wb,
	// status flags register
	output logic [7:0]      o_flags,
	// side effect strobes
	output logic            o_sleep,
	output logic            o_wdog_restart,
	output logic            o_break
);

	// ======================================================================
	// state
	logic [7:0] status_flags_register; // live flags
	logic [7:0] next_flags;            // flags after this op
	logic [7:0] next_value;            // register result
	logic       next_we;               // result valid
	logic [7:0] rd;                    // operand shorthand

	assign rd = i_req.operand;

	// ======================================================================
	// zcnv flag update shared by the shift family
	function automatic logic [7:0] shift_flags(input logic [7:0] f,
		input logic [7:0] res, input logic cout);
		logic [7:0] g;
		g = f;
		g[BSF_FLAG_C] = cout;
		g[BSF_FLAG_Z] = (res == 8'h00);
		g[BSF_FLAG_N] = res[7];
		g[BSF_FLAG_V] = res[7] ^ cout;
		return g;
	endfunction

	// ======================================================================
	// combinational execute
	always_comb begin
		next_flags = status_flags_register;
		next_value = rd;
		next_we    = 1'b0;
		if (i_valid) begin
			unique case (i_req.op)
				BSF_OP_ROT_LEFT: begin
					// carry enters bit 0, bit 7 leaves to carry
					next_value = {rd[6:0], status_flags_register[BSF_FLAG_C]};
					next_flags = shift_flags(status_flags_register,
						next_value, rd[7]);
					next_we    = 1'b1;
				end
				BSF_OP_ROT_RIGHT: begin
					// carry enters bit 7, bit 0 leaves to carry
					next_value = {status_flags_register[BSF_FLAG_C], rd[7:1]};
					next_flags = shift_flags(status_flags_register,
						next_value, rd[0]);
					next_we    = 1'b1;
				end
				BSF_OP_ARITH_SHR: begin
					// sign bit replicated
					next_value = {rd[7], rd[7:1]};
					next_flags = shift_flags(status_flags_register,
						next_value, rd[0]);
					next_we    = 1'b1;
				end
				BSF_OP_NIB_SWAP: begin
					next_value = {rd[3:0], rd[7:4]};
					next_we    = 1'b1;
				end
				BSF_OP_BIT_TO_T: begin
					next_flags[BSF_FLAG_T] = rd[i_req.sel];
				end
				BSF_OP_T_TO_BIT: begin
					next_value[i_req.sel] = status_flags_register[BSF_FLAG_T];
					next_we    = 1'b1;
				end
				BSF_OP_FLAG_SET: begin
					// named set forms are this op with a fixed index
					next_flags[i_req.sel] = 1'b1;
				end
				BSF_OP_FLAG_CLEAR: begin
					next_flags[i_req.sel] = 1'b0;
				end
				// sleep, restart and break hold flags
				BSF_OP_SLEEP, BSF_OP_WDOG_RST, BSF_OP_BREAK: begin
					next_flags = status_flags_register;
				end
				default: begin
					// idle or illegal code: nothing changes
					next_flags = status_flags_register;
				end
			endcase
		end
	end

	// ======================================================================
	// flags register
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			status_flags_register <= BSF_FLAGS_RST;
		end else begin
			status_flags_register <= next_flags;
		end
	end

	// ======================================================================
	// write back register
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			o_wb <= '{we: 1'b0, value: BSF_RESULT_RST};
		end else begin
			o_wb <= '{we: next_we, value: next_value};
		end
	end

	// ======================================================================
	// one cycle strobes for the power, watchdog and debug logic
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			o_sleep        <= 1'b0;
			o_wdog_restart <= 1'b0;
			o_break        <= 1'b0;
		end else begin
			o_sleep        <= i_valid && (i_req.op == BSF_OP_SLEEP);
			o_wdog_restart <= i_valid && (i_req.op == BSF_OP_WDOG_RST);
			o_break        <= i_valid && (i_req.op == BSF_OP_BREAK);
		end
	end

	assign o_flags = status_flags_register;

	// ======================================================================
	// checks
	a_rol_result: assert property (@(posedge i_clk) disable iff (i_srst)
		i_valid && i_req.op == BSF_OP_ROT_LEFT |=> o_wb.we &&
		o_wb.value == {$past(rd[6:0]), $past(o_flags[BSF_FLAG_C])} &&
		o_flags[BSF_FLAG_C] == $past(rd[7]))
		else $error("rotate left wrong");
	a_ror_result: assert property (@(posedge i_clk) disable iff (i_srst)
		i_valid && i_req.op == BSF_OP_ROT_RIGHT |=> o_wb.we &&
		o_wb.value == {$past(o_flags[BSF_FLAG_C]), $past(rd[7:1])} &&
		o_flags[BSF_FLAG_C] == $past(rd[0]))
		else $error("rotate right wrong");
	a_asr_sign_kept: assert property (@(posedge i_clk) disable iff (i_srst)
		i_valid && i_req.op == BSF_OP_ARITH_SHR |=>
		o_wb.value == {$past(rd[7]), $past(rd[7:1])} &&
		o_flags[BSF_FLAG_Z] == (o_wb.value == 8'h00))
		else $error("arith shift wrong");
	a_swap_flags: assert property (@(posedge i_clk) disable iff (i_srst)
		i_valid && i_req.op == BSF_OP_NIB_SWAP |=>
		$stable(o_flags) && o_wb.value == {$past(rd[3:0]), $past(rd[7:4])})
		else $error("swap wrong");
	a_bit_to_t: assert property (@(posedge i_clk) disable iff (i_srst)
		i_valid && i_req.op == BSF_OP_BIT_TO_T |=>
		o_flags[BSF_FLAG_T] == $past(rd[i_req.sel]) && !o_wb.we &&
		(o_flags[5:0] == $past(o_flags[5:0])))
		else $error("bit to transfer flag wrong");
	a_t_to_bit: assert property (@(posedge i_clk) disable iff (i_srst)
		i_valid && i_req.op == BSF_OP_T_TO_BIT |=> $stable(o_flags) &&
		o_wb.value[$past(i_req.sel)] == $past(o_flags[BSF_FLAG_T]))
		else $error("transfer flag to bit wrong");
	a_flag_set_one: assert property (@(posedge i_clk) disable iff (i_srst)
		i_valid && i_req.op == BSF_OP_FLAG_SET |=>
		o_flags == ($past(o_flags) | (8'h01 << $past(i_req.sel))))
		else $error("flag set wrong");
	a_flag_clr_one: assert property (@(posedge i_clk) disable iff (i_srst)
		i_valid && i_req.op == BSF_OP_FLAG_CLEAR |=>
		o_flags == ($past(o_flags) & ~(8'h01 << $past(i_req.sel))))
		else $error("flag clear wrong");
	a_sleep_pulse: assert property (@(posedge i_clk) disable iff (i_srst)
		i_valid && i_req.op == BSF_OP_SLEEP |=> o_sleep && $stable(o_flags)
		##1 !o_sleep || $past(i_valid && i_req.op == BSF_OP_SLEEP))
		else $error("sleep strobe wrong");
	a_wdog_pulse: assert property (@(posedge i_clk) disable iff (i_srst)
		o_wdog_restart |-> $past(i_valid && i_req.op == BSF_OP_WDOG_RST))
		else $error("restart strobe without cause");
	a_break_flags: assert property (@(posedge i_clk) disable iff (i_srst)
		i_valid && i_req.op == BSF_OP_BREAK |=> o_break && $stable(o_flags))
		else $error("break changed flags");

	c_rol_carry: cover property (@(posedge i_clk)
		i_valid && i_req.op == BSF_OP_ROT_LEFT && rd[7]);
	c_asr_neg: cover property (@(posedge i_clk)
		i_valid && i_req.op == BSF_OP_ARITH_SHR && rd == 8'h81);
	c_bst_bld: cover property (@(posedge i_clk)
		i_valid && i_req.op == BSF_OP_BIT_TO_T
		##1 i_valid && i_req.op == BSF_OP_T_TO_BIT);
	c_set_h: cover property (@(posedge i_clk)
		i_valid && i_req.op == BSF_OP_FLAG_SET && i_req.sel == BSF_FLAG_H);

endmodule : bsf_unit

`default_nettype wire

/* dv/bsf_unit_bench.sv */
`timescale 1ns/1ns
`default_nettype none

module bit_shift_flag_unit_bench;
	import bsf_pkg::*;

	// ======================================================================
	// expected outcome of one issue slot
	typedef struct packed {
		logic       chk; // slot is compared
		logic       we;  // write back expected
		logic [7:0] val; // write back value
		logic [7:0] fl;  // status flags
		logic       slp; // sleep strobe
		logic       wd;  // watchdog restart strobe
		logic       brk; // break strobe
	} bsf_exp_t;

	logic       i_clk     = 1'b0;  // core clock
	logic       i_srst    = 1'b1;  // synchronous reset
	logic       i_valid   = 1'b0;  // issue strobe
	bsf_req_t   i_req     = '0;    // issued instruction
	bsf_wb_t    o_wb;              // write back
	logic [7:0] o_flags;           // status flags
	logic       o_sleep;           // sleep strobe
	logic       o_wdog_restart;    // watchdog restart strobe
	logic       o_break;           // break strobe
	bsf_exp_t   pend      = '0;    // expectation of the slot just driven
	bsf_exp_t   cur       = '0;    // expectation of the slot now visible
	logic [7:0] mflags    = 8'h00; // model of the status flags
	integer     seed      = 32'h3FAA;
	int         err_count = 0;
	int         check_count = 0;

	bsf_unit bsf_unit_i (
		.i_clk(i_clk), .i_srst(i_srst), .i_valid(i_valid), .i_req(i_req),
		.o_wb(o_wb), .o_flags(o_flags), .o_sleep(o_sleep),
		.o_wdog_restart(o_wdog_restart), .o_break(o_break));

	// ======================================================================
	// clock, 10 ns period
	initial forever #5 i_clk = ~i_clk;

	// compare one value and count it
	task automatic chk(input string nm, input logic [7:0] seen,
			input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// outputs answer one edge after the request, compared mid cycle
	always @(posedge i_clk) cur <= pend;
	always @(negedge i_clk) if (cur.chk) begin
		chk("flags", o_flags, cur.fl);
		chk("write", {7'h00, o_wb.we}, {7'h00, cur.we});
		if (cur.we) chk("value", o_wb.value, cur.val);
		chk("strobes", {5'h00, o_sleep, o_wdog_restart, o_break},
			{5'h00, cur.slp, cur.wd, cur.brk});
	end

	// ======================================================================
	// drive one slot at the rising edge and work out its outcome
	task automatic issue(input logic rst, input logic v, input logic [4:0] op,
			input logic [2:0] sel, input logic [7:0] d);
		bsf_exp_t   e;
		logic [7:0] r;
		logic       c;
		@(posedge i_clk);
		i_srst  <= rst;
		i_valid <= v;
		i_req   <= {op, sel, d};
		e = '0;
		e.chk = 1'b1;
		r = d;
		c = 1'b0;
		if (rst) mflags = BSF_FLAGS_RST;
		else if (v) case (op)
			BSF_OP_ROT_LEFT:   begin r = {d[6:0], mflags[BSF_FLAG_C]}; c = d[7]; end
			BSF_OP_ROT_RIGHT:  begin r = {mflags[BSF_FLAG_C], d[7:1]}; c = d[0]; end
			BSF_OP_ARITH_SHR:  begin r = {d[7], d[7:1]}; c = d[0]; end
			BSF_OP_NIB_SWAP:   r = {d[3:0], d[7:4]};
			BSF_OP_BIT_TO_T:   mflags[BSF_FLAG_T] = d[sel];
			BSF_OP_T_TO_BIT:   r[sel] = mflags[BSF_FLAG_T];
			BSF_OP_FLAG_SET:   mflags[sel] = 1'b1;
			BSF_OP_FLAG_CLEAR: mflags[sel] = 1'b0;
			BSF_OP_SLEEP:      e.slp = 1'b1;
			BSF_OP_WDOG_RST:   e.wd = 1'b1;
			BSF_OP_BREAK:      e.brk = 1'b1;
			default: ;
		endcase
		if (!rst && v && op inside {BSF_OP_ROT_LEFT, BSF_OP_ROT_RIGHT,
				BSF_OP_ARITH_SHR}) begin
			mflags[BSF_FLAG_Z] = (r == 8'h00);
			mflags[BSF_FLAG_C] = c;
			mflags[BSF_FLAG_N] = r[7];
			mflags[BSF_FLAG_V] = r[7] ^ c;
		end
		e.we = !rst && v && (op inside {BSF_OP_ROT_LEFT, BSF_OP_ROT_RIGHT,
			BSF_OP_ARITH_SHR, BSF_OP_NIB_SWAP, BSF_OP_T_TO_BIT});
		e.val = r;
		e.fl  = mflags;
		pend <= e;
	endtask

	// verdict and end of run
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// ======================================================================
	// main sequence: corner cases then random traffic
	initial begin
		repeat (5) issue(1'b1, 1'b0, 5'h00, 3'h0, 8'h00);
		// carry in zero, top bit out, then carry back in
		issue(1'b0, 1'b1, BSF_OP_FLAG_CLEAR, BSF_FLAG_C, 8'h00);
		issue(1'b0, 1'b1, BSF_OP_ROT_LEFT, 3'h0, 8'h80);
		issue(1'b0, 1'b1, BSF_OP_ROT_RIGHT, 3'h0, 8'h01);
		issue(1'b0, 1'b1, BSF_OP_ARITH_SHR, 3'h0, 8'h81);
		// every flag index set and cleared back to back
		for (int i = 0; i < 8; i++) begin
			issue(1'b0, 1'b1, BSF_OP_FLAG_SET, i[2:0], 8'h00);
			issue(1'b0, 1'b1, BSF_OP_FLAG_CLEAR, i[2:0], 8'hFF);
			issue(1'b0, 1'b1, BSF_OP_FLAG_SET, i[2:0], 8'h55);
		end
		// strobes back to back, unknown code, idle slot with an op
		issue(1'b0, 1'b1, BSF_OP_SLEEP, 3'h0, 8'h00);
		issue(1'b0, 1'b1, BSF_OP_WDOG_RST, 3'h0, 8'h00);
		issue(1'b0, 1'b1, BSF_OP_BREAK, 3'h0, 8'h00);
		issue(1'b0, 1'b1, 5'h1F, 3'h0, 8'h00);
		issue(1'b0, 1'b0, BSF_OP_ROT_LEFT, 3'h0, 8'hFF);
		$display("corner tests done");
		repeat (400) issue(($unsigned($random(seed)) % 60) == 0,
			($random(seed) % 8) != 0, 5'($unsigned($random(seed)) % 13),
			3'($random(seed)), 8'($random(seed)));
		issue(1'b0, 1'b0, 5'h00, 3'h0, 8'h00);
		repeat (2) @(negedge i_clk);
		$display("random tests done");
		end_of_test;
	end

	// hang guard
	initial begin
		#100000;
		err_count++;
		$display("run limit reached");
		end_of_test;
	end

endmodule // bit_shift_flag_unit_bench

`default_nettype wire
